// ### inc/ufc_pkg.sv
// Purpose: Constants and types for the USB function control register group
// Assumes: 8-bit memory-mapped register port from the embedded controller
// Notes:   Offsets are the byte addresses of the controller's data space
package ufc_pkg;
   localparam logic [15:0] ADDR_FRAME_HIGH  = 16'hFFFA;
   localparam logic [15:0] ADDR_FRAME_LOW   = 16'hFFFB;
   localparam logic [15:0] ADDR_CONTROL     = 16'hFFFC;
   localparam logic [15:0] ADDR_INT_ENABLE  = 16'hFFFD;

   localparam logic [7:0]  INT_ENABLE_RESET = 8'h00;
   localparam logic [7:0]  INT_ENABLE_MASK  = 8'hFD;
   localparam logic [7:0]  CONTROL_MASK     = 8'hF0;
   localparam logic [7:0]  CONTROL_RESET    = 8'h00;

   localparam int          CTL_CONNECT_BIT  = 7;
   localparam int          CTL_FENABLE_BIT  = 6;
   localparam int          CTL_WAKEUP_BIT   = 5;
   localparam int          CTL_SCOPE_BIT    = 4;

   localparam int          FRAME_BITS       = 11;
   localparam int          CLK_FREQ_HZ      = 200_000_000;
   localparam int          PSEUDO_PERIOD_US = 1000;
   localparam int          PSEUDO_CYCLES    = CLK_FREQ_HZ / 1_000_000 * PSEUDO_PERIOD_US;

   typedef struct packed {
      logic bus_reset_event;
      logic suspend_event;
      logic resume_event;
      logic frame_start_event;
      logic pseudo_frame_start_event;
      logic setup_complete_event;
      logic reserved;
      logic setup_overwrite_event;
   } ufc_events_t;

   typedef struct packed {
      logic                  valid;
      logic [FRAME_BITS-1:0] number;
   } ufc_sof_t;
endpackage : ufc_pkg

// ### logic/ufc_regs.sv
// Purpose: USB function control, interrupt enable and frame number registers
// Assumes: Register port and USB events synchronous to clk
// Notes:   Status register itself lives elsewhere; its bits arrive as events
//
// Function
// - Interrupt enable holds one enable per event, bit 1 reserved and reading zero.
// - Connect bit drives the pull-up output while set, else it floats.
// - Connect bit survives a USB bus reset.
// - While function enable is zero, every USB transaction is ignored.
// - A USB bus reset clears function enable.
// - Remote wake-up bit requests upstream resume signalling.
// - With reset scope set, a bus reset resets all logic except the connect and reset scope bits.
// - With reset scope set, the reset output pin is asserted on a bus reset.
// - Reset scope bit survives a USB bus reset.
// - Frame low byte holds frame number bits 7:0 taken from each received SOF.
// - When not locked, the frame number increments at each pseudo SOF.
// - Frame high byte holds bits 10:8 in bits 2:0, bits 7:3 read zero.
// - When not locked, a pseudo SOF is generated every 1 ms.
`timescale 1ns/1ps
module ufc_regs
   import ufc_pkg::*;
#(
   parameter int PSEUDO_COUNT = PSEUDO_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   input  wire logic        usb_bus_reset,
   input  wire ufc_sof_t    sof_in,
   input  wire logic        frame_locked,
   input  wire ufc_events_t status_flags,
   input  wire logic        usb_transaction,
   output logic             transaction_accept,
   output logic             pseudo_frame_start_event,
   output logic             resume_request,
   output logic             reset_output_pin,
   output logic             system_reset_request,
   output logic             data_plus_pullup_out,
   output logic             data_plus_pullup_oe,
   output logic             usb_irq
);

   logic [7:0]            int_enable;
   logic [7:0]            next_int_enable;
   logic [7:0]            control;
   logic [7:0]            next_control;
   logic [FRAME_BITS-1:0] frame_number;
   logic [FRAME_BITS-1:0] next_frame_number;
   logic [31:0]           pseudo_cnt;
   logic [31:0]           next_pseudo_cnt;
   logic                  pseudo_tick;
   logic                  scoped_reset;
   logic [7:0]            flag_bits;
   logic [7:0]            gated_events;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      return a == target;
   endfunction : hit

   assign scoped_reset = usb_bus_reset & control[CTL_SCOPE_BIT];
   assign pseudo_tick  = !frame_locked && (pseudo_cnt == 32'(PSEUDO_COUNT - 1));

   always_comb begin
      next_int_enable   = int_enable;
      next_control      = control;
      next_frame_number = frame_number;
      next_pseudo_cnt   = pseudo_cnt + 32'h1;
      if (reg_wr && hit(reg_addr, ADDR_INT_ENABLE)) begin
         next_int_enable = reg_wdata & INT_ENABLE_MASK;
      end
      if (reg_wr && hit(reg_addr, ADDR_CONTROL)) begin
         next_control = reg_wdata & CONTROL_MASK;
      end
      if (frame_locked || pseudo_tick || sof_in.valid) begin
         next_pseudo_cnt = 32'h0;
      end
      if (sof_in.valid) begin
         next_frame_number = sof_in.number;
      end else if (pseudo_tick) begin
         next_frame_number = frame_number + 11'h1;
      end
      if (usb_bus_reset) begin
         next_control[CTL_FENABLE_BIT] = 1'b0;
         next_pseudo_cnt               = 32'h0;
         if (control[CTL_SCOPE_BIT]) begin
            next_int_enable               = INT_ENABLE_RESET;
            next_frame_number             = '0;
            next_control[CTL_WAKEUP_BIT]  = 1'b0;
         end
         // Connect and scope bits keep their value
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_enable   <= INT_ENABLE_RESET;
         control      <= CONTROL_RESET;
         frame_number <= '0;
         pseudo_cnt   <= 32'h0;
      end else begin
         int_enable   <= next_int_enable;
         control      <= next_control;
         frame_number <= next_frame_number;
         pseudo_cnt   <= next_pseudo_cnt;
      end
   end

   always_comb begin
      reg_rdata = 8'h00;
      if (reg_rd) begin
         unique case (1'b1)
            hit(reg_addr, ADDR_INT_ENABLE): reg_rdata = int_enable;
            hit(reg_addr, ADDR_CONTROL):    reg_rdata = control;
            hit(reg_addr, ADDR_FRAME_LOW):  reg_rdata = frame_number[7:0];
            hit(reg_addr, ADDR_FRAME_HIGH): reg_rdata = {5'h00, frame_number[10:8]};
            default:                        reg_rdata = 8'h00;
         endcase
      end
   end

   assign data_plus_pullup_out     = control[CTL_CONNECT_BIT];
   assign data_plus_pullup_oe      = control[CTL_CONNECT_BIT];
   assign transaction_accept       = usb_transaction & control[CTL_FENABLE_BIT];
   assign resume_request           = control[CTL_WAKEUP_BIT];
   assign reset_output_pin         = scoped_reset;
   assign system_reset_request     = scoped_reset;
   assign pseudo_frame_start_event = pseudo_tick;
   assign flag_bits                = status_flags;

   generate
      for (genvar gi = 0; gi < 8; gi++) begin : g_irq_gate
         assign gated_events[gi] = flag_bits[gi] & int_enable[gi] & INT_ENABLE_MASK[gi];
      end
   endgenerate
   assign usb_irq = |gated_events;

   a_enable_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      int_enable[1] == 1'b0) else $error("reserved enable bit set");
   a_write_enable: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, ADDR_INT_ENABLE) && !(usb_bus_reset && control[CTL_SCOPE_BIT])
      |=> int_enable == ($past(reg_wdata) & 8'hFD)) else $error("enable write lost");
   a_pullup_follow: assert property (@(posedge clk) disable iff (!rst_n)
      data_plus_pullup_oe == control[7]) else $error("pullup mismatch");
   a_connect_kept: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && !reg_wr |=> $stable(control[7])) else $error("connect lost");
   a_accept_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !control[6] |-> !transaction_accept) else $error("transaction accepted");
   a_enable_cleared: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset |=> !control[6]) else $error("enable not cleared");
   a_scope_kept: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && !reg_wr |=> $stable(control[4])) else $error("scope lost");
   a_reset_pin: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && control[4] |-> reset_output_pin) else $error("reset pin idle");
   a_sof_load: assert property (@(posedge clk) disable iff (!rst_n)
      sof_in.valid && !usb_bus_reset |=> frame_number == $past(sof_in.number))
      else $error("frame not loaded");
   a_pseudo_inc: assert property (@(posedge clk) disable iff (!rst_n)
      pseudo_tick && !sof_in.valid && !usb_bus_reset
      |=> frame_number == $past(frame_number) + 11'h1) else $error("no increment");
   a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      usb_irq |-> |(status_flags & int_enable)) else $error("spurious irq");

   a_wakeup_set: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, ADDR_CONTROL) && reg_wdata[CTL_WAKEUP_BIT] && !scoped_reset
      |=> resume_request) else $error("wake-up not driven");
   a_scope_clear: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && control[CTL_SCOPE_BIT]
      |=> int_enable == 8'h00 && frame_number == 11'h000 && !resume_request)
      else $error("scoped reset incomplete");
   a_system_reset: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && control[CTL_SCOPE_BIT]
      |-> system_reset_request) else $error("system reset missing");
   a_reset_pin_idle: assert property (@(posedge clk) disable iff (!rst_n)
      (!usb_bus_reset || !control[CTL_SCOPE_BIT])
      |-> !reset_output_pin) else $error("reset pin stray");
   a_high_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, ADDR_FRAME_HIGH)
      |-> reg_rdata[7:3] == 5'h00) else $error("frame high reserved bits set");
   a_low_read: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, ADDR_FRAME_LOW)
      |-> reg_rdata == frame_number[7:0]) else $error("frame low read wrong");
   a_frame_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !sof_in.valid && !pseudo_tick && !usb_bus_reset
      |=> $stable(frame_number)) else $error("frame number drifted");
   a_pseudo_locked: assert property (@(posedge clk) disable iff (!rst_n)
      frame_locked
      |-> !pseudo_frame_start_event) else $error("pseudo start while locked");
   a_pseudo_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      pseudo_frame_start_event
      |=> !pseudo_frame_start_event) else $error("pseudo start too long");
   a_counter_lock: assert property (@(posedge clk) disable iff (!rst_n)
      frame_locked || sof_in.valid
      |=> pseudo_cnt == 32'h0) else $error("pseudo counter not restarted");
   a_pullup_float: assert property (@(posedge clk) disable iff (!rst_n)
      !control[CTL_CONNECT_BIT]
      |-> !data_plus_pullup_oe) else $error("pullup driven while off");
   a_enable_accept: assert property (@(posedge clk) disable iff (!rst_n)
      usb_transaction && control[CTL_FENABLE_BIT]
      |-> transaction_accept) else $error("transaction refused");
   a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
      (|(flag_bits & int_enable))
      |-> usb_irq) else $error("interrupt missing");
   a_enable_kept: assert property (@(posedge clk) disable iff (!rst_n)
      !(reg_wr && hit(reg_addr, ADDR_INT_ENABLE)) && !usb_bus_reset
      |=> $stable(int_enable)) else $error("enable changed unasked");
   a_connect_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, ADDR_CONTROL)
      |=> data_plus_pullup_oe == $past(reg_wdata[CTL_CONNECT_BIT]))
      else $error("connect write lost");
   a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, ADDR_CONTROL) && !usb_bus_reset
      |=> control[CTL_FENABLE_BIT] == $past(reg_wdata[CTL_FENABLE_BIT]))
      else $error("function enable write lost");

   c_pseudo: cover property (@(posedge clk) disable iff (!rst_n) pseudo_tick);
   c_sof: cover property (@(posedge clk) disable iff (!rst_n) sof_in.valid);
   c_scoped: cover property (@(posedge clk) disable iff (!rst_n) scoped_reset);
   c_irq: cover property (@(posedge clk) disable iff (!rst_n) usb_irq);
   c_wakeup: cover property (@(posedge clk) disable iff (!rst_n) resume_request);
endmodule : ufc_regs

// ### verification/ufc_host_model.sv
// Purpose: Host side of the bus: bus reset, frame starts, lock, transactions
// Assumes: Lines change just after a rising edge of clk
// Notes:   Frame number lines carry the inverse value once valid drops
`timescale 1ns/1ps
module ufc_host_model
   import ufc_pkg::*;
(
   input  wire logic clk,
   output logic      usb_bus_reset,
   output ufc_sof_t  sof_in,
   output logic      frame_locked,
   output logic      usb_transaction
);
   initial begin
      usb_bus_reset = 1'b0;
      sof_in = '0;
      frame_locked = 1'b1;
      usb_transaction = 1'b0;
   end
   task automatic set_line(input logic rst, input logic lock, input logic xact);
      @(posedge clk);
      usb_bus_reset <= rst;
      frame_locked <= lock;
      usb_transaction <= xact;
   endtask : set_line
   task automatic send_sof(input logic [10:0] n);
      @(posedge clk);
      sof_in <= {1'b1, n};
      @(posedge clk);
      sof_in <= {1'b0, ~n};
   endtask : send_sof
endmodule : ufc_host_model

// ### verification/ufc_regs_tb_top.sv
// Purpose: Self-checking bench for the USB function control registers
// Assumes: Short pseudo frame period for simulation
// Notes:   Register reads sampled mid-cycle while the read strobe is high
`timescale 1ns/1ps
module ufc_regs_tb_top;
   import ufc_pkg::*;
   localparam int PC = 20;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, xact, bus_rst, locked;
   logic [15:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, d, e, f;
   ufc_sof_t sof;
   ufc_events_t flags = '0;
   logic acc, pulse, wake, rst_pin, sys_rst, pu, pu_oe, irq;
   int bad_count = 0, total_checks = 0, c;
   always #2.5 clk = ~clk;
   ufc_regs #(.PSEUDO_COUNT(PC)) u_ufc_regs (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .usb_bus_reset(bus_rst), .sof_in(sof), .frame_locked(locked), .status_flags(flags),
      .usb_transaction(xact), .transaction_accept(acc), .pseudo_frame_start_event(pulse),
      .resume_request(wake), .reset_output_pin(rst_pin), .system_reset_request(sys_rst),
      .data_plus_pullup_out(pu), .data_plus_pullup_oe(pu_oe), .usb_irq(irq));
   ufc_host_model u_ufc_host_model (.clk(clk), .usb_bus_reset(bus_rst), .sof_in(sof),
      .frame_locked(locked), .usb_transaction(xact));
   task automatic tally_and_finish;
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
      total_checks++;
      if (g !== x) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask : chk8
   task automatic chk1(input string n, input logic x, input logic g);
      chk8(n, {7'h00, x}, {7'h00, g});
   endtask : chk1
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0; reg_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(negedge clk);
      v = reg_rdata;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic wait_pulse(output int n);
      n = 0;
      do begin @(negedge clk); n++; end while (pulse !== 1'b1 && n < 200);
   endtask : wait_pulse
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h7E9F49D2));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_CONTROL, d); chk8("ctl reset", 8'h00, d);
      rd(16'hFFF9, d); chk8("unmapped", 8'h00, d);
      for (int i = 0; i < 16; i++) begin
         e = (i < 8) ? 8'hFF : 8'($urandom);
         f = (i < 8) ? 8'h01 << i : 8'($urandom);
         wr(ADDR_INT_ENABLE, e);
         rd(ADDR_INT_ENABLE, d); chk8("int enable", e & 8'hFD, d);
         @(posedge clk) flags <= f;
         @(negedge clk) chk1("irq", |(f & e & 8'hFD), irq);
      end
      f = 8'($urandom);
      u_ufc_host_model.send_sof({3'h5, f});
      wr(ADDR_FRAME_LOW, 8'h00); wr(16'hFFF9, 8'hFF);
      rd(ADDR_FRAME_LOW, d); chk8("frame low", f, d);
      rd(ADDR_FRAME_HIGH, d); chk8("frame high", 8'h05, d);
      wr(ADDR_CONTROL, 8'h20);
      @(negedge clk) chk1("resume", 1'b1, wake);
      wr(ADDR_CONTROL, 8'hD0);
      @(negedge clk) chk1("resume off", 1'b0, wake);
      u_ufc_host_model.set_line(1'b0, 1'b1, 1'b1);
      @(negedge clk) chk1("accept", 1'b1, acc);
      chk1("pullup", 1'b1, pu & pu_oe);
      u_ufc_host_model.set_line(1'b1, 1'b1, 1'b1);
      @(negedge clk) chk1("reset pin", 1'b1, rst_pin & sys_rst);
      u_ufc_host_model.set_line(1'b0, 1'b1, 1'b1);
      @(negedge clk) chk1("accept", 1'b0, acc);
      rd(ADDR_CONTROL, d); chk8("ctl scoped", 8'h90, d);
      rd(ADDR_INT_ENABLE, d); chk8("int scoped", 8'h00, d);
      rd(ADDR_FRAME_LOW, d); chk8("frame scoped", 8'h00, d);
      wr(ADDR_CONTROL, 8'hE0);
      u_ufc_host_model.set_line(1'b1, 1'b1, 1'b0);
      @(negedge clk) chk1("reset pin", 1'b0, rst_pin);
      u_ufc_host_model.set_line(1'b0, 1'b1, 1'b0);
      rd(ADDR_CONTROL, d); chk8("ctl unscoped", 8'hA0, d);
      wr(ADDR_CONTROL, 8'h00);
      @(negedge clk) chk1("pullup oe", 1'b0, pu_oe);
      u_ufc_host_model.send_sof(11'h3FF);
      u_ufc_host_model.set_line(1'b0, 1'b0, 1'b0);
      wait_pulse(c);
      wait_pulse(c); chk8("pulse period", 8'(PC), 8'(c));
      rd(ADDR_FRAME_LOW, d); chk8("frame inc", 8'h01, d);
      rd(ADDR_FRAME_HIGH, d); chk8("frame inc hi", 8'h04, d);
      tally_and_finish();
   end
endmodule : ufc_regs_tb_top
